// >>> cmc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// storage responder
// ------------------------------
module cmc_flash_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr,
    input wire logic er,
    input wire logic fail_mode,
    output logic done,
    output logic fail
);
    logic [2:0] cnt;
    // fail flips only while cnt is 0 or 7, and holds fail_mode around the done window, so a stale level is never trusted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 3'h0;
            done <= 1'b0;
            fail <= 1'b0;
        end else begin
            cnt <= (wr | er) ? 3'h7 : (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
            done <= cnt inside {3'h3, 3'h4, 3'h5};
            fail <= (cnt != 3'h0 && cnt != 3'h7) ? fail_mode : ~fail;
        end
    end
endmodule
`default_nettype wire

// >>> cmc_pkg.sv
`default_nettype none
package cmc_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_WIPE = 8'h0c;
    localparam logic [7:0] A_LAST = 8'h10;
    localparam logic [7:0] A_CFG = 8'h14;
    localparam int CTRL_CRC = 2;
    localparam int CMD_ARG = 8;
    localparam int ST_BUSY = 16;
    localparam int ST_CARD = 17;
    localparam int ST_REV = 18;
    localparam int CFG_PROTO = 8;
    localparam int CFG_BAUD = 16;
    localparam int CFG_FLAG = 24;
    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [7:0] ADDR_RST = 8'h01;
    localparam logic [7:0] PROTO_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [31:0] WIPE_RST = 32'h0;
    localparam logic [15:0] ADDR_MAX = 16'h00ff;
    localparam logic [15:0] PROTO_MAX = 16'h0005;
    localparam logic [15:0] BAUD_MAX = 16'h000d;
    localparam logic [15:0] FLAG_MAX = 16'h0001;
    localparam logic [7:0] HEX_D0 = 8'h30;
    localparam logic [7:0] HEX_D9 = 8'h39;
    localparam logic [7:0] HEX_UA = 8'h41;
    localparam logic [7:0] HEX_UF = 8'h46;
    // ----------------------------------------
    // error codes
    // ----------------------------------------
    localparam logic [15:0] E_NONE = 16'h0000;
    localparam logic [15:0] E_MODE = 16'h0064;
    localparam logic [15:0] E_FAULT = 16'h0068;
    localparam logic [15:0] E_INFO = 16'h0070;
    localparam logic [15:0] E_RCARD = 16'h0071;
    localparam logic [15:0] E_ADDR = 16'h0072;
    localparam logic [15:0] E_FWR = 16'h0073;
    localparam logic [15:0] E_PROTO = 16'h0074;
    localparam logic [15:0] E_BAUD = 16'h0075;
    localparam logic [15:0] E_FLAG = 16'h0076;
    localparam logic [15:0] E_HEX = 16'h0077;
    localparam logic [15:0] E_FER = 16'h0078;
    localparam logic [15:0] E_FRST = 16'h0079;
    // ----------------------------------------
    // status message
    // ----------------------------------------
    localparam logic [7:0] MSG_TYPE = 8'h01;
    localparam logic [5:0] LEN_CRC = 6'h20;
    localparam logic [5:0] LEN_NOCRC = 6'h1e;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CNT_W = 28;
    localparam int CLK_KHZ = 250000;
    localparam int NOTE_MS = 500;
    localparam int POLL_MS = 10;
    localparam int BEEP_MS = 100;
    localparam int BLINK_MS = 250;
    localparam int LINGER_MS = 300;
    localparam int NOTE_CYC = NOTE_MS * CLK_KHZ;
    localparam int POLL_CYC = POLL_MS * CLK_KHZ;
    localparam int BEEP_CYC = BEEP_MS * CLK_KHZ;
    localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
    localparam int LINGER_CYC = LINGER_MS * CLK_KHZ;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        M_BASIC = 2'h0, M_ADV = 2'h1, M_ENT = 2'h2, M_CUST = 2'h3
    } cmc_mode_t;
    typedef enum logic [7:0] {
        OP_INFO = 8'h01, OP_ADDR = 8'h02, OP_PROTO = 8'h03,
        OP_BAUD = 8'h04, OP_FLAG = 8'h05, OP_HEX = 8'h06,
        OP_FRST = 8'h07, OP_FWR = 8'h08, OP_FER = 8'h09
    } cmc_op_t;
    typedef enum logic [1:0] {
        FL_IDLE = 2'h0, FL_WR = 2'h1, FL_ER = 2'h2
    } cmc_fl_t;
endpackage
`default_nettype wire

// >>> cmc_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cmc_tb_top import cmc_pkg::*;;
    typedef struct packed {
        logic [1:0] m;
        logic [7:0] o;
        logic [15:0] a;
        logic [15:0] e;
    } cmc_row_t;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, card_uid = 0, r, msg_uid;
    logic pready, pslverr, card_present = 0, card_err = 0, hw_rev2 = 0;
    logic flash_done, flash_fail, fmode = 0, e, poll_req, flash_wr, flash_er;
    logic buzzer, led_red, led_green, led_blue, msg_send;
    logic [5:0] msg_len;
    logic [7:0] msg_type, msg_addr;
    int err_count = 0, checks_done = 0, msg_cnt = 0;
    int polls = 0, p0 = 0, wrs = 0, ers = 0;
    wire logic [1:0] watch;
    assign watch = {buzzer, msg_send};
    // ------------------------------
    // clock, parts
    // ------------------------------
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (msg_send === 1'b1) msg_cnt++;
    // pulses counted mid-cycle, clear of the launching edge
    always @(negedge clk_sys) begin
        if (poll_req === 1'b1) polls++;
        if (flash_wr === 1'b1) wrs++;
        if (flash_er === 1'b1) ers++;
    end
    // short counts keep the card timing walk within a few hundred cycles
    cmc_top #(.P_NOTE(28'd40), .P_POLL(28'd8), .P_BEEP(28'd5),
        .P_BLINK(28'd4), .P_LINGER(28'd6)) i_dut (.clk_sys, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .card_present, .card_err, .card_uid, .flash_done, .flash_fail,
        .hw_rev2, .poll_req, .flash_wr, .flash_er, .buzzer, .led_red,
        .led_green, .led_blue, .msg_send, .msg_len, .msg_type, .msg_addr,
        .msg_uid);
    cmc_flash_model i_flash (.clk_sys(clk_sys), .rst(rst), .wr(flash_wr),
        .er(flash_er), .fail_mode(fmode), .done(flash_done),
        .fail(flash_fail));
    // ------------------------------
    // tasks
    // ------------------------------
    task print_verdict;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask
    task hang;
        err_count++;
        $display("ERROR %0t wait expired", $time);
        print_verdict;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang;
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wt(input int b);
        int n;
        n = 0;
        while (watch[b] !== 1'b1) begin
            @(posedge clk_sys);
            n++;
            if (n > 100) hang;
        end
    endtask
    // ------------------------------
    // cases
    // ------------------------------
    cmc_row_t rows[21] = '{
        {2'h1, OP_INFO, 16'h0, E_NONE}, {2'h1, OP_INFO, 16'h1, E_INFO},
        {2'h1, OP_ADDR, 16'hff, E_NONE}, {2'h1, OP_ADDR, 16'h100, E_ADDR},
        {2'h1, OP_PROTO, 16'h5, E_NONE}, {2'h1, OP_PROTO, 16'h6, E_PROTO},
        {2'h1, OP_BAUD, 16'hd, E_NONE}, {2'h1, OP_BAUD, 16'he, E_BAUD},
        {2'h1, OP_FLAG, 16'h1, E_NONE}, {2'h1, OP_FLAG, 16'h2, E_FLAG},
        {2'h1, OP_HEX, 16'h46, E_NONE}, {2'h1, OP_HEX, 16'h30, E_NONE},
        {2'h1, OP_HEX, 16'h47, E_HEX}, {2'h1, OP_HEX, 16'h3a, E_HEX},
        {2'h1, OP_HEX, 16'h61, E_HEX}, {2'h1, OP_FRST, 16'h1, E_FRST},
        {2'h1, 8'hff, 16'h0, E_FAULT}, {2'h0, OP_ADDR, 16'h5, E_MODE},
        {2'h0, OP_FRST, 16'h0, E_MODE}, {2'h0, OP_FWR, 16'h0, E_MODE},
        {2'h2, OP_FER, 16'h0, E_MODE}};
    logic [7:0] fo[3] = '{OP_FWR, OP_FER, OP_FWR};
    logic [15:0] fe[3] = '{E_FWR, E_FER, E_NONE};
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 0;
        apb(0, A_CFG, 0);
        chk(r, 32'h1);
        chk({8'h0, msg_type, msg_addr, 2'h0, msg_len},
            {8'h0, MSG_TYPE, 8'h1, 2'h0, LEN_NOCRC});
        foreach (rows[i]) begin
            apb(1, A_CTRL, {30'h0, rows[i].m});
            apb(1, A_CMD, {8'h0, rows[i].a, rows[i].o});
            apb(0, A_STAT, 0);
            chk(r[15:0], rows[i].e);
        end
        apb(0, A_CFG, 0);
        chk(r, 32'h010d05ff);
        apb(0, 8'h40, 0);
        chk({e, r[30:0]}, 32'h80000000);
        // storage: failed write, failed erase, then a clean write
        foreach (fo[i]) begin
            fmode <= (i < 2);
            apb(1, A_CTRL, 32'h1);
            apb(1, A_CMD, {24'h0, fo[i]});
            for (int k = 0; k < 20 && (k < 2 || r[16] !== 1'b0); k++)
                apb(0, A_STAT, 0);
            chk(r[15:0], fe[i]);
        end
        chk({wrs[15:0], ers[15:0]}, {16'h2, 16'h1});
        // card arrival, hold, removal
        apb(1, A_CTRL, 32'h5);
        card_uid <= 32'h1234abcd;
        card_present <= 1;
        wt(1);
        wt(0);
        chk({8'h0, msg_type, msg_addr, 2'h0, msg_len},
            {8'h0, MSG_TYPE, 8'hff, 2'h0, LEN_CRC});
        chk(msg_uid, 32'h1234abcd);
        p0 = polls;
        repeat (32) @(posedge clk_sys);
        chk(polls - p0, 32'h4);
        chk({msg_cnt[29:0], led_red ^ led_green, led_blue},
            {30'h1, 2'h2});
        apb(0, A_LAST, 0);
        chk(r, 32'h1234abcd);
        card_present <= 0;
        repeat (30) @(posedge clk_sys);
        chk({buzzer, led_red, led_green, led_blue}, 0);
        apb(0, A_LAST, 0);
        chk(r, 0);
        // the same id as the stored wipe card restores defaults silently
        apb(1, A_WIPE, 32'h1234abcd);
        card_present <= 1;
        repeat (30) @(posedge clk_sys);
        apb(0, A_CFG, 0);
        chk(r, 32'h1);
        chk(msg_cnt, 1);
        card_present <= 0;
        apb(1, A_CMD, {8'h0, 16'h1, OP_FLAG});
        repeat (30) @(posedge clk_sys);
        card_err <= 1;
        card_present <= 1;
        repeat (30) @(posedge clk_sys);
        apb(0, A_STAT, 0);
        chk(r[15:0], E_RCARD);
        // mid-run reset with the revision 2 strap and a card still held
        hw_rev2 <= 1;
        card_err <= 0;
        rst <= 1;
        repeat (8) @(posedge clk_sys);
        rst <= 0;
        repeat (32) @(posedge clk_sys);
        apb(0, A_STAT, 0);
        chk(r[18:0], 19'h60000);
        chk({led_red ^ led_blue, led_green}, 2'h2);
        chk({msg_cnt[15:0], msg_addr, 2'h0, msg_len},
            {16'h2, ADDR_RST, 2'h0, LEN_NOCRC});
        print_verdict;
    end
endmodule
`default_nettype wire

// >>> cmc_top.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - commands restricted to advanced level are refused with 0x0064
// - new device address above 255 is refused with 0x0072
// - checksum protocol value above 0x05 is refused with 0x0074
// - serial speed value above 0x0d is refused with 0x0075
// - reset-card flag other than 0 or 1 is refused with 0x0076
// - hex character outside 0-9 and A-F gives 0x0077
// - failed read of the reset card gives 0x0071
// - failed storage write gives 0x0073
// - failed storage erase gives 0x0078
// - unknown factory-reset subcommand gives 0x0079
// - bad device-information parameters give 0x0070
// - internal fault conditions give 0x0068
// - antenna field is polled on its own, without master request
// - same card as last one is not processed twice while it stays in the field
// - card matching stored reset-card id restores factory configuration
// - new card, or changed card after 500ms: beep, LED, message
// - LED blinks while the card stays in the field
// - card removal returns LED and buzzer to idle
// - master commands are served at once; a setting write in the same cycle as a reset-card restore is dropped
// - status message goes out at the end of a monitoring cycle
// - second LED colour is green on revision 1, blue on revision 2
// - status message type byte is 0x01
// - status message is 32 bytes with checksum, 30 without
// - after removal the LED stays on briefly then goes dark
module cmc_top import cmc_pkg::*; #(
    parameter logic [CNT_W-1:0] P_NOTE = CNT_W'(NOTE_CYC),
    parameter logic [CNT_W-1:0] P_POLL = CNT_W'(POLL_CYC),
    parameter logic [CNT_W-1:0] P_BEEP = CNT_W'(BEEP_CYC),
    parameter logic [CNT_W-1:0] P_BLINK = CNT_W'(BLINK_CYC),
    parameter logic [CNT_W-1:0] P_LINGER = CNT_W'(LINGER_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_present,
    input wire logic card_err,
    input wire logic [31:0] card_uid,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic hw_rev2,
    output logic poll_req,
    output logic flash_wr,
    output logic flash_er,
    output logic buzzer,
    output logic led_red,
    output logic led_green,
    output logic led_blue,
    output logic msg_send,
    output logic [5:0] msg_len,
    output logic [7:0] msg_type,
    output logic [7:0] msg_addr,
    output logic [31:0] msg_uid
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // uid is assumed stable whenever card_present is high
    logic [36:0] sy1, sy2;
    logic s_pres, s_cerr, s_fdone, s_ffail, s_rev;
    logic [31:0] s_uid;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sy1 <= '0;
            sy2 <= '0;
        end else begin
            sy1 <= {hw_rev2, flash_fail, flash_done, card_err,
                    card_present, card_uid};
            sy2 <= sy1;
        end
    end
    assign {s_rev, s_ffail, s_fdone, s_cerr, s_pres, s_uid} = sy2;

    // strap caught once the synchroniser has filled
    logic [1:0] st_cnt;
    logic rev2;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_cnt <= 2'h0;
            rev2 <= 1'b0;
        end else if (st_cnt != 2'h3) begin
            st_cnt <= st_cnt + 2'h1;
            if (st_cnt == 2'h2) begin
                rev2 <= s_rev;
            end
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic setup, take, wr_go, cmd_go;
    logic [1:0] mode;
    logic crc_en;
    logic [31:0] wipe_uid, last_uid;
    logic [15:0] err;
    logic [7:0] dev_addr, proto, baud;
    logic wflag, pres_q;
    cmc_fl_t fl_st;
    assign setup = psel & ~penable;
    assign take = psel & penable & pready;
    assign wr_go = take & pwrite;
    assign cmd_go = wr_go & (paddr == A_CMD);

    // one wait-free access cycle; commands never stall the bus
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            prdata <= '0;
            if (setup) begin
                unique case (paddr)
                    A_CTRL: prdata <= {29'h0, crc_en, mode};
                    A_CMD: prdata <= '0;
                    A_STAT: prdata <= {13'h0, rev2, pres_q,
                        fl_st != FL_IDLE, err};
                    A_WIPE: prdata <= wipe_uid;
                    A_LAST: prdata <= last_uid;
                    A_CFG: prdata <= {7'h0, wflag, baud, proto,
                        dev_addr};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // command check
    // ----------------------------------------
    logic [7:0] op;
    logic [15:0] arg;
    logic [15:0] res;
    logic adv, hex_ok;
    assign op = pwdata[7:0];
    assign arg = pwdata[CMD_ARG +: 16];
    assign adv = mode == M_ADV;
    assign hex_ok = (arg[7:0] >= HEX_D0 && arg[7:0] <= HEX_D9) ||
                    (arg[7:0] >= HEX_UA && arg[7:0] <= HEX_UF);
    always_comb begin
        res = E_NONE;
        case (op)
            OP_INFO: if (arg != 16'h0) res = E_INFO;
            OP_ADDR: begin
                if (!adv) res = E_MODE;
                else if (arg > ADDR_MAX) res = E_ADDR;
            end
            OP_PROTO: if (arg > PROTO_MAX) res = E_PROTO;
            OP_BAUD: if (arg > BAUD_MAX) res = E_BAUD;
            OP_FLAG: if (arg > FLAG_MAX) res = E_FLAG;
            OP_HEX: if (!hex_ok) res = E_HEX;
            OP_FRST: begin
                if (!adv) res = E_MODE;
                else if (arg != 16'h0) res = E_FRST;
            end
            OP_FWR, OP_FER: begin
                if (!adv) res = E_MODE;
                else if (fl_st != FL_IDLE) res = E_FAULT;
            end
            default: res = E_FAULT;
        endcase
    end

    // ----------------------------------------
    // card monitor
    // ----------------------------------------
    logic [CNT_W-1:0] poll_cnt, gap_cnt, beep_cnt, blink_cnt;
    logic [CNT_W-1:0] linger_cnt;
    logic tick, arrive, swap, seen, wipe_hit, notify, removed;
    logic rd_bad, factory, phase, msg_pend, fd_q;
    assign tick = poll_cnt == '0;
    assign arrive = tick & s_pres & ~pres_q;
    // a held card is processed once; a swap obeys the guard gap
    assign swap = tick & s_pres & pres_q & (s_uid != last_uid) &
                  (gap_cnt == '0);
    assign seen = (arrive | swap) & ~s_cerr;
    assign rd_bad = (arrive | swap) & s_cerr & wflag;
    assign wipe_hit = seen & wflag & (s_uid == wipe_uid);
    assign notify = seen & ~wipe_hit;
    assign removed = tick & ~s_pres & pres_q;
    assign factory = wipe_hit |
                     (cmd_go && op == OP_FRST && res == E_NONE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            poll_cnt <= '0;
            poll_req <= 1'b0;
            pres_q <= 1'b0;
        end else begin
            poll_cnt <= tick ? P_POLL - 1'b1 : poll_cnt - 1'b1;
            poll_req <= tick;
            if (tick) begin
                pres_q <= s_pres;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_uid <= '0;
        end else if (removed) begin
            last_uid <= '0;
        end else if (seen) begin
            last_uid <= s_uid;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_cnt <= '0;
        end else if (notify) begin
            gap_cnt <= P_NOTE - 1'b1;
        end else if (gap_cnt != '0) begin
            gap_cnt <= gap_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            beep_cnt <= '0;
            buzzer <= 1'b0;
        end else begin
            if (removed) begin
                beep_cnt <= '0;
            end else if (notify) begin
                beep_cnt <= P_BEEP;
            end else if (beep_cnt != '0) begin
                beep_cnt <= beep_cnt - 1'b1;
            end
            buzzer <= beep_cnt != '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blink_cnt <= '0;
            phase <= 1'b0;
            linger_cnt <= '0;
        end else begin
            if (!pres_q || blink_cnt == '0) begin
                blink_cnt <= P_BLINK - 1'b1;
            end else begin
                blink_cnt <= blink_cnt - 1'b1;
            end
            if (!pres_q) begin
                phase <= 1'b1;
            end else if (blink_cnt == '0) begin
                phase <= ~phase;
            end
            if (removed) begin
                linger_cnt <= P_LINGER;
            end else if (pres_q) begin
                linger_cnt <= '0;
            end else if (linger_cnt != '0) begin
                linger_cnt <= linger_cnt - 1'b1;
            end
        end
    end

    // red marks the blink and the brief hold after removal
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            led_red <= 1'b0;
            led_green <= 1'b0;
            led_blue <= 1'b0;
        end else begin
            led_red <= pres_q ? phase : linger_cnt != '0;
            led_green <= pres_q & ~phase & ~rev2;
            led_blue <= pres_q & ~phase & rev2;
        end
    end

    // ----------------------------------------
    // status message
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            msg_pend <= 1'b0;
            msg_send <= 1'b0;
            msg_len <= LEN_NOCRC;
            msg_type <= MSG_TYPE;
            msg_addr <= ADDR_RST;
            msg_uid <= '0;
        end else begin
            msg_send <= tick & msg_pend;
            if (notify) begin
                msg_pend <= 1'b1;
            end else if (tick) begin
                msg_pend <= 1'b0;
            end
            msg_type <= MSG_TYPE;
            if (tick & msg_pend) begin
                msg_len <= crc_en ? LEN_CRC : LEN_NOCRC;
                msg_addr <= dev_addr;
                msg_uid <= last_uid;
            end
        end
    end

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode <= M_BASIC;
            crc_en <= 1'b0;
            wipe_uid <= WIPE_RST;
        end else if (factory) begin
            mode <= M_BASIC;
            crc_en <= 1'b0;
        end else if (wr_go && paddr == A_CTRL) begin
            mode <= pwdata[1:0];
            crc_en <= pwdata[CTRL_CRC];
        end else if (wr_go && paddr == A_WIPE) begin
            wipe_uid <= pwdata;
        end
    end

    // only a factory restore or a command that passed its check touches a field
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dev_addr <= ADDR_RST;
            proto <= PROTO_RST;
            baud <= BAUD_RST;
            wflag <= 1'b0;
        end else if (factory) begin
            dev_addr <= ADDR_RST;
            proto <= PROTO_RST;
            baud <= BAUD_RST;
            wflag <= 1'b0;
        end else if (cmd_go && res == E_NONE) begin
            if (op == OP_ADDR) dev_addr <= arg[7:0];
            if (op == OP_PROTO) proto <= arg[7:0];
            if (op == OP_BAUD) baud <= arg[7:0];
            if (op == OP_FLAG) wflag <= arg[0];
        end
    end

    // ----------------------------------------
    // storage sequencer and error code
    // ----------------------------------------
    logic fdone_rise;
    assign fdone_rise = s_fdone & ~fd_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fl_st <= FL_IDLE;
            flash_wr <= 1'b0;
            flash_er <= 1'b0;
            fd_q <= 1'b0;
        end else begin
            fd_q <= s_fdone;
            flash_wr <= 1'b0;
            flash_er <= 1'b0;
            unique case (fl_st)
                FL_IDLE: if (cmd_go && res == E_NONE) begin
                    if (op == OP_FWR) begin
                        fl_st <= FL_WR;
                        flash_wr <= 1'b1;
                    end else if (op == OP_FER) begin
                        fl_st <= FL_ER;
                        flash_er <= 1'b1;
                    end
                end
                FL_WR, FL_ER: if (fdone_rise) fl_st <= FL_IDLE;
                default: fl_st <= FL_IDLE;
            endcase
        end
    end

    // command answer wins over a background event in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err <= E_NONE;
        end else if (cmd_go) begin
            err <= res;
        end else if (fdone_rise) begin
            unique case (fl_st)
                FL_WR: err <= s_ffail ? E_FWR : E_NONE;
                FL_ER: err <= s_ffail ? E_FER : E_NONE;
                default: err <= E_FAULT;
            endcase
        end else if (rd_bad) begin
            err <= E_RCARD;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_mode_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_ADDR && mode != M_ADV |=> err == E_MODE)
        else $error("advanced-only command not refused");
    a_addr_keep: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_ADDR && adv && arg > ADDR_MAX
        |=> err == E_ADDR && $stable(dev_addr))
        else $error("bad address applied or not reported");
    a_proto_chk: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_PROTO |=> (err == E_PROTO) ==
        ($past(arg) > PROTO_MAX))
        else $error("protocol range check wrong");
    a_baud_chk: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_BAUD && arg > BAUD_MAX
        |=> err == E_BAUD && $stable(baud))
        else $error("speed range check wrong");
    a_flag_chk: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_FLAG && arg > FLAG_MAX |=> err == E_FLAG)
        else $error("flag range check wrong");
    a_hex_chk: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_go && op == OP_HEX |=> (err == E_HEX) != $past(hex_ok))
        else $error("hex character check wrong");
    a_msg_len: assert property (@(posedge clk_sys) disable iff (rst)
        msg_send |-> msg_len == ($past(crc_en) ? LEN_CRC : LEN_NOCRC))
        else $error("status message length wrong");
    a_msg_after: assert property (@(posedge clk_sys) disable iff (rst)
        notify ##1 (!tick)[*1] |-> !msg_send ##0 msg_pend)
        else $error("status message not held for cycle end");
    a_beep_new: assert property (@(posedge clk_sys) disable iff (rst)
        notify |=> ##1 buzzer)
        else $error("no beep on new card");
    a_idle_gone: assert property (@(posedge clk_sys) disable iff (rst)
        removed |=> ##1 !buzzer && !led_green && !led_blue)
        else $error("indicators not idle after removal");
    a_fwr_fail: assert property (@(posedge clk_sys) disable iff (rst)
        fdone_rise && s_ffail && fl_st == FL_WR && !cmd_go
        |=> err == E_FWR)
        else $error("storage write failure not reported");
endmodule
`default_nettype wire
